// ===== hw/fault_policy_pkg.sv
// constants, types and decoders shared by the current-limit lock fault policy
`default_nettype none
package fault_policy_pkg;

    // axi4-lite register byte offsets
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  SETTINGS_OFFSET = 8'h00;
    localparam logic [7:0]  CONTROL_OFFSET  = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h08;
    localparam logic [31:0] SETTINGS_RESET  = 32'h0000_0000;
    localparam logic [1:0]  AXI_OKAY        = 2'h0;
    localparam logic [1:0]  AXI_SLVERR      = 2'h2;

    // field positions in fault_settings_two
    localparam int RESPONSE_LSB = 16;
    localparam int FILTER_LSB   = 13;
    localparam int HYST_LSB     = 11;
    localparam int UV_THR_LSB   = 8;
    localparam int UV_REC_BIT   = 7;
    localparam int OV_THR_LSB   = 4;
    localparam int OV_REC_BIT   = 3;
    localparam int RETRY_LSB    = 0;

    // control and status bit positions
    localparam int CLEAR_BIT        = 0;
    localparam int ST_LOCK_FAULT    = 0;
    localparam int ST_LOCK_LATCHED  = 1;
    localparam int ST_UV_FAULT      = 2;
    localparam int ST_OV_FAULT      = 3;
    localparam int ST_BRIDGE_LSB    = 4;
    localparam int ST_FAULT_PIN     = 6;
    localparam int ST_LOCK_REPORT   = 7;
    localparam int ST_RETRY_LSB     = 8;
    localparam int ST_LOCK_LEVEL    = 16;

    // current_limit_lock_response codes
    localparam logic [2:0] RESP_LATCH_TRISTATE = 3'h0;
    localparam logic [2:0] RESP_LATCH_LOW      = 3'h1;
    localparam logic [2:0] RESP_LATCH_HIGH     = 3'h2;
    localparam logic [2:0] RESP_RETRY_TRISTATE = 3'h3;
    localparam logic [2:0] RESP_RETRY_LOW      = 3'h4;
    localparam logic [2:0] RESP_RETRY_HIGH     = 3'h5;
    localparam logic [2:0] RESP_REPORT         = 3'h6;
    localparam logic [2:0] RESP_DISABLED       = 3'h7;

    // bridge output states
    localparam logic [1:0] BRIDGE_RUN        = 2'h0;
    localparam logic [1:0] BRIDGE_TRISTATE   = 2'h1;
    localparam logic [1:0] BRIDGE_LOW_BRAKE  = 2'h2;
    localparam logic [1:0] BRIDGE_HIGH_BRAKE = 2'h3;

    // one-microsecond filter step, rounded up to clocks
    localparam int CLK_PERIOD_NS      = 50;
    localparam int FILTER_STEP_NS     = 1000;
    localparam int FILTER_STEP_CYCLES = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CNT_W       = 8;

    // bus voltage is sampled in half-volt steps
    localparam int VOLT_W   = 8;
    localparam int RETRY_W  = 5;
    localparam int TIMER_W  = 16;
    localparam logic [RETRY_W-1:0] RETRY_SAT = 5'h1F;

    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_RETRY_WAIT,
        LOCK_LATCHED,
        LOCK_REPORT
    } lock_state_t;

    // undervoltage threshold in half volts, zero means no check
    function automatic logic [VOLT_W-1:0] uv_threshold(input logic [2:0] code);
        case (code)
            3'h1:    uv_threshold = 8'h0C;
            3'h2:    uv_threshold = 8'h0E;
            3'h3:    uv_threshold = 8'h10;
            3'h4:    uv_threshold = 8'h14;
            3'h5:    uv_threshold = 8'h1C;
            3'h6:    uv_threshold = 8'h20;
            3'h7:    uv_threshold = 8'h24;
            default: uv_threshold = 8'h00;
        endcase
    endfunction : uv_threshold

    // overvoltage threshold in half volts, zero means no limit
    function automatic logic [VOLT_W-1:0] ov_threshold(input logic [2:0] code);
        case (code)
            3'h1:    ov_threshold = 8'h24;
            3'h2:    ov_threshold = 8'h28;
            3'h3:    ov_threshold = 8'h2C;
            3'h4:    ov_threshold = 8'h38;
            3'h5:    ov_threshold = 8'h3C;
            3'h6:    ov_threshold = 8'h40;
            3'h7:    ov_threshold = 8'h44;
            default: ov_threshold = 8'h00;
        endcase
    endfunction : ov_threshold

    // hysteresis in half volts
    function automatic logic [VOLT_W-1:0] hysteresis(input logic [1:0] code);
        case (code)
            2'h1:    hysteresis = 8'h02;
            2'h2:    hysteresis = 8'h04;
            2'h3:    hysteresis = 8'h06;
            default: hysteresis = 8'h01;
        endcase
    endfunction : hysteresis

    // allowed retries, zero means unlimited
    function automatic logic [RETRY_W-1:0] retry_limit(input logic [2:0] code);
        case (code)
            3'h1:    retry_limit = 5'h02;
            3'h2:    retry_limit = 5'h03;
            3'h3:    retry_limit = 5'h05;
            3'h4:    retry_limit = 5'h07;
            3'h5:    retry_limit = 5'h0A;
            3'h6:    retry_limit = 5'h0F;
            3'h7:    retry_limit = 5'h14;
            default: retry_limit = 5'h00;
        endcase
    endfunction : retry_limit

endpackage : fault_policy_pkg
`default_nettype wire

// ===== hw/lock_deglitch.sv
// synchroniser and persistence filter for the lock input
`default_nettype none
module lock_deglitch
    import fault_policy_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clk_en,
    input  wire logic       lock_raw,
    input  wire logic [2:0] filter_code,
    output logic            lock_filtered
);

    typedef struct packed {
        logic                    sync_a;
        logic                    sync_b;
        logic [FILTER_CNT_W-1:0] run_cnt;
        logic                    filtered;
    } deglitch_state_t;

    deglitch_state_t st_ff;
    deglitch_state_t nxt_st;
    logic [FILTER_CNT_W-1:0] need_cycles;

    // filter is code microseconds; code zero passes straight
    always_comb begin
        nxt_st      = st_ff;
        need_cycles = FILTER_CNT_W'(32'(filter_code) * FILTER_STEP_CYCLES);
        nxt_st.sync_a = lock_raw;
        nxt_st.sync_b = st_ff.sync_a;
        if (!st_ff.sync_b) begin
            nxt_st.run_cnt = '0;          // any dropout restarts the filter
        end else if (st_ff.run_cnt < need_cycles) begin
            nxt_st.run_cnt = st_ff.run_cnt + 1'b1;
        end
        nxt_st.filtered = st_ff.sync_b && (nxt_st.run_cnt >= need_cycles); // R9
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign lock_filtered = st_ff.filtered;

endmodule : lock_deglitch
`default_nettype wire

// ===== hw/current_limit_lock_fault_policy.sv
// lock fault policy, bus voltage checks, axi4-lite registers
//
// Behaviour
// R1 - Code 0 latches the fault, pin low, bridge tristated.
// R2 - Code 1 latches the fault, pin low, low sides on.
// R3 - Code 2 latches the fault, pin low, high sides on.
// R4 - Code 3 retries, then latches tristated past the limit.
// R5 - Code 4 retries up to the limit, braking low while faulted.
// R6 - Code 5 retries, then latches with a high-side brake.
// R7 - Code 6 only drives the pin as a report.
// R8 - Code 7 ignores the lock.
// R9 - The lock must persist 0 to 7 microseconds before it counts.
// R10 - Voltage faults set at threshold, clear beyond it by the hysteresis.
// R11 - Hysteresis codes 0 to 3 select 0.5, 1, 2 and 3 volts.
// R12 - Undervoltage threshold code 0 is off, code 1 is 6 volts.
// R13 - Retry limit codes mean unlimited, 2, 3, 5, 7, 10, 15 and 20.
// R14 - Undervoltage recovery 0 latches, 1 clears once back in bounds.
// R15 - The retry interval is an input; any fault clear zeroes the retry count; the code zeroes it only on a clear write in retry wait or latched.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`default_nettype none
module current_limit_lock_fault_policy
    import fault_policy_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               clk_en,
    input  wire logic [ADDR_W-1:0]  awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [ADDR_W-1:0]  araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               current_limit_lock_raw,
    input  wire logic [VOLT_W-1:0]  bus_voltage,
    input  wire logic [TIMER_W-1:0] lock_retry_interval,
    output logic                    fault_indicator_n,
    output logic [1:0]              bridge_mode
);

    typedef struct packed {
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;
        logic               aw_held;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_held;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic [31:0]        settings;
        lock_state_t        lock_state;
        logic [RETRY_W-1:0] retry_cnt;
        logic [TIMER_W-1:0] retry_timer;
        logic               uv_fault;
        logic               ov_fault;
        logic [1:0]         bridge_mode;
        logic               fault_n;
    } policy_state_t;

    policy_state_t st_ff;
    policy_state_t nxt_st;

    logic               lock_filtered;
    logic               sw_clear;
    logic               lock_detect;
    logic               lock_faulted;
    logic [2:0]         response;
    logic [RETRY_W-1:0] limit;
    logic [VOLT_W-1:0]  uv_thr;
    logic [VOLT_W-1:0]  ov_thr;
    logic [VOLT_W-1:0]  hyst;
    logic               uv_set;
    logic               uv_bounds;
    logic               ov_set;
    logic               ov_bounds;

    // byte-lane merge by strobes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strb);
        logic [31:0] merged;
        merged = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return merged;
    endfunction : merge_bytes

    // offsets the slave answers
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == SETTINGS_OFFSET) || (addr == CONTROL_OFFSET) ||
               (addr == STATUS_OFFSET);
    endfunction : is_mapped

    // bridge state while the lock fault is held
    function automatic logic [1:0] response_bridge(input logic [2:0] code);
        case (code)
            RESP_LATCH_LOW, RESP_RETRY_LOW:   return BRIDGE_LOW_BRAKE;  // R2 R5
            RESP_LATCH_HIGH, RESP_RETRY_HIGH: return BRIDGE_HIGH_BRAKE; // R3 R6
            default:                          return BRIDGE_TRISTATE;   // R1 R4
        endcase
    endfunction : response_bridge

    // status word built from live state
    function automatic logic [31:0] status_word(input policy_state_t s, input logic lvl);
        logic [31:0] w;
        w = '0;
        w[ST_LOCK_FAULT]   = (s.lock_state == LOCK_RETRY_WAIT) ||
                             (s.lock_state == LOCK_LATCHED);
        w[ST_LOCK_LATCHED] = (s.lock_state == LOCK_LATCHED);
        w[ST_UV_FAULT]     = s.uv_fault;
        w[ST_OV_FAULT]     = s.ov_fault;
        w[ST_BRIDGE_LSB +: 2]       = s.bridge_mode;
        w[ST_FAULT_PIN]             = ~s.fault_n;
        w[ST_LOCK_REPORT]           = (s.lock_state == LOCK_REPORT);
        w[ST_RETRY_LSB +: RETRY_W]  = s.retry_cnt;
        w[ST_LOCK_LEVEL]            = lvl;
        return w;
    endfunction : status_word

    // lock input filter, synchroniser inside
    lock_deglitch u_deglitch (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .clk_en        (clk_en),
        .lock_raw      (current_limit_lock_raw),
        .filter_code   (st_ff.settings[FILTER_LSB +: 3]),
        .lock_filtered (lock_filtered)
    );

    // decoded configuration fields
    assign response  = st_ff.settings[RESPONSE_LSB +: 3];
    assign limit     = retry_limit(st_ff.settings[RETRY_LSB +: 3]);              // R13
    assign uv_thr    = uv_threshold(st_ff.settings[UV_THR_LSB +: 3]);           // R12
    assign ov_thr    = ov_threshold(st_ff.settings[OV_THR_LSB +: 3]);
    assign hyst      = hysteresis(st_ff.settings[HYST_LSB +: 2]);               // R11
    assign lock_detect = lock_filtered && (response != RESP_DISABLED);          // R8

    // nine-bit sums: threshold plus hysteresis cannot wrap
    assign uv_set    = (uv_thr != '0) && (bus_voltage <= uv_thr);                // R10
    assign uv_bounds = (uv_thr == '0) ||
                       ({1'b0, bus_voltage} > ({1'b0, uv_thr} + {1'b0, hyst})); // R10
    assign ov_set    = (ov_thr != '0) && (bus_voltage >= ov_thr);                // R10
    assign ov_bounds = (ov_thr == '0) ||
                       ({1'b0, bus_voltage} < ({1'b0, ov_thr} - {1'b0, hyst})); // R10

    // clear is a one-shot control write
    assign sw_clear = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid &&
                      (st_ff.aw_addr == CONTROL_OFFSET) && st_ff.w_strb[0] &&
                      st_ff.w_data[CLEAR_BIT];

    // whole next-state computation
    always_comb begin
        nxt_st = st_ff;

        // address and data taken in either order
        if (awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = awaddr;
            nxt_st.awready = 1'b0;
        end
        if (wvalid && st_ff.wready) begin
            nxt_st.w_held  = 1'b1;
            nxt_st.w_data  = wdata;
            nxt_st.w_strb  = wstrb;
            nxt_st.wready  = 1'b0;
        end

        // commit with both halves held; status writes are ignored
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            if (st_ff.aw_addr == SETTINGS_OFFSET) begin
                nxt_st.settings = merge_bytes(st_ff.settings, st_ff.w_data, st_ff.w_strb);
            end
            nxt_st.bresp   = is_mapped(st_ff.aw_addr) ? AXI_OKAY : AXI_SLVERR;
            nxt_st.bvalid  = 1'b1;
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
        end
        // readies return after the response: one write at a time
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid  = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end

        // read data one cycle after the address
        if (arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rresp   = is_mapped(araddr) ? AXI_OKAY : AXI_SLVERR;
            if (araddr == SETTINGS_OFFSET) begin
                nxt_st.rdata = st_ff.settings;
            end else if (araddr == STATUS_OFFSET) begin
                nxt_st.rdata = status_word(st_ff, lock_filtered);
            end else begin
                nxt_st.rdata = '0;   // control reads back as zero, it only pulses
            end
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end

        // lock fault sequencing
        case (st_ff.lock_state)
            LOCK_IDLE: begin
                if (lock_detect) begin
                    case (response)
                        RESP_REPORT: begin
                            nxt_st.lock_state = LOCK_REPORT;                    // R7
                        end
                        RESP_RETRY_TRISTATE, RESP_RETRY_LOW, RESP_RETRY_HIGH: begin
                            // limit zero never runs out; the fault after
                            // the last allowed retry latches
                            if ((limit != '0) && (st_ff.retry_cnt >= limit)) begin
                                nxt_st.lock_state = LOCK_LATCHED;               // R4 R5 R6
                            end else begin
                                nxt_st.lock_state  = LOCK_RETRY_WAIT;           // R4 R5 R6
                                nxt_st.retry_timer = (lock_retry_interval == '0) ?
                                                     TIMER_W'(1) : lock_retry_interval; // R15
                            end
                        end
                        default: begin
                            nxt_st.lock_state = LOCK_LATCHED;                   // R1 R2 R3
                        end
                    endcase
                end
            end
            LOCK_RETRY_WAIT: begin
                if (sw_clear) begin
                    nxt_st.lock_state = LOCK_IDLE;
                    nxt_st.retry_cnt  = '0;                                     // R15
                end else if (st_ff.retry_timer <= TIMER_W'(1)) begin
                    nxt_st.lock_state = LOCK_IDLE;                              // R4 R5 R6
                    if (st_ff.retry_cnt != RETRY_SAT) begin
                        nxt_st.retry_cnt = st_ff.retry_cnt + 1'b1;
                    end
                end else begin
                    nxt_st.retry_timer = st_ff.retry_timer - 1'b1;
                end
            end
            LOCK_LATCHED: begin
                // a lock still present keeps the fault: set wins
                if (sw_clear && !lock_detect) begin
                    nxt_st.lock_state = LOCK_IDLE;                              // R1
                    nxt_st.retry_cnt  = '0;                                     // R15
                end
            end
            LOCK_REPORT: begin
                if (!lock_detect || (response != RESP_REPORT)) begin
                    nxt_st.lock_state = LOCK_IDLE;                              // R7
                end
            end
            default: begin
                nxt_st.lock_state = LOCK_IDLE;
            end
        endcase

        // voltage faults: set outranks clear
        nxt_st.uv_fault = uv_set || (st_ff.uv_fault &&
                          !(uv_bounds && (st_ff.settings[UV_REC_BIT] || sw_clear))); // R14
        nxt_st.ov_fault = ov_set || (st_ff.ov_fault &&
                          !(ov_bounds && (st_ff.settings[OV_REC_BIT] || sw_clear))); // R10

        // outputs follow the next state
        lock_faulted = (nxt_st.lock_state == LOCK_RETRY_WAIT) ||
                       (nxt_st.lock_state == LOCK_LATCHED);
        if (nxt_st.uv_fault || nxt_st.ov_fault) begin
            nxt_st.bridge_mode = BRIDGE_TRISTATE;   // supply out of range wins over brakes
        end else if (lock_faulted) begin
            nxt_st.bridge_mode = response_bridge(response);                     // R1 R2 R3
        end else begin
            nxt_st.bridge_mode = BRIDGE_RUN;                                    // R7 R8
        end
        nxt_st.fault_n = !(lock_faulted || nxt_st.uv_fault || nxt_st.ov_fault ||
                           (nxt_st.lock_state == LOCK_REPORT));                 // R1 R7
    end

    // state register; clk_en low freezes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff          <= '0;
            st_ff.awready  <= 1'b1;
            st_ff.wready   <= 1'b1;
            st_ff.arready  <= 1'b1;
            st_ff.settings <= SETTINGS_RESET;
            st_ff.fault_n  <= 1'b1;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // every output is a field of the state register
    assign awready           = st_ff.awready;
    assign wready            = st_ff.wready;
    assign bvalid            = st_ff.bvalid;
    assign bresp             = st_ff.bresp;
    assign arready           = st_ff.arready;
    assign rvalid            = st_ff.rvalid;
    assign rresp             = st_ff.rresp;
    assign rdata             = st_ff.rdata;
    assign bridge_mode       = st_ff.bridge_mode;
    assign fault_indicator_n = st_ff.fault_n;

endmodule : current_limit_lock_fault_policy
`default_nettype wire

// ===== tb/fault_policy_checker.sv
// port assertions for the lock fault policy
`default_nettype none
module fault_policy_checker import fault_policy_pkg::*; (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              awready,
    input wire logic              wready,
    input wire logic              bvalid,
    input wire logic              arready,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              current_limit_lock_raw,
    input wire logic [VOLT_W-1:0] bus_voltage,
    input wire logic              fault_indicator_n,
    input wire logic [1:0]        bridge_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both halves taken at one edge
    sequence s_wr_launch; $fell(awready) && $fell(wready); endsequence
    a_read_answer: assert property ($fell(arready) |-> rvalid)
        else $error("read answer missing");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_read_done: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read not released");
    a_write_answer: assert property (s_wr_launch |=> bvalid)
        else $error("write answer late");
    a_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while busy");
    a_slverr_zero: assert property (rvalid && rresp == AXI_SLVERR |-> rdata == 32'h0)
        else $error("error read carries data");
    a_brake_pin: assert property (bridge_mode != BRIDGE_RUN |-> !fault_indicator_n)
        else $error("bridge stopped without fault pin");
    a_sync_delay: assert property ($rose(current_limit_lock_raw) && fault_indicator_n
        && $stable(bus_voltage) |=> fault_indicator_n [*2]) else $error("lock acted early");
endmodule : fault_policy_checker
bind current_limit_lock_fault_policy fault_policy_checker i_chk (.aclk, .aresetn, .awready,
    .wready, .bvalid, .arready, .rvalid, .rready, .rdata, .rresp, .current_limit_lock_raw,
    .bus_voltage, .fault_indicator_n, .bridge_mode);
`default_nettype wire

// ===== tb/motor_stage_model.sv
// power stage and motor: lock current needs a running bridge
`default_nettype none
module motor_stage_model import fault_policy_pkg::*; (
    input wire logic [1:0] bridge_mode,
    input wire logic       aclk,
    input wire logic       lock_cmd,
    input wire logic [7:0] volt_cmd,
    output logic           lock_raw,
    output logic [7:0]     bus_voltage
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {lock_raw, bus_voltage} = 9'h018;
    // braking or tristating starves the current
    always @(posedge aclk) begin
        lock_raw <= lock_cmd && bridge_mode == BRIDGE_RUN;
        bus_voltage <= volt_cmd;
    end
endmodule : motor_stage_model
`default_nettype wire

// ===== tb/current_limit_lock_fault_policy_bench.sv
// self-checking bench for the lock fault policy
`default_nettype none
module current_limit_lock_fault_policy_bench import fault_policy_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'h0, aresetn = 1'h0, lock_cmd = 1'h0, lock_raw, fault_indicator_n;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, volt_cmd = 8'h18, bus_voltage;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic [1:0]  bresp, rresp, bridge_mode;
    int          error_cnt = 0, total_checks = 0;
    // expected {pin, bridge} per response code, then per voltage
    logic [2:0]  exp_lock [8] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3, 3'h0, 3'h4};
    logic [7:0]  volt [7] = '{8'h0D, 8'h0C, 8'h0D, 8'h0E, 8'h24, 8'h23, 8'h22};
    logic [2:0]  exp_v [7] = '{3'h4, 3'h1, 3'h1, 3'h4, 3'h1, 3'h1, 3'h4};
    always #25 aclk = ~aclk;
    current_limit_lock_fault_policy i_dut (.aclk, .aresetn, .clk_en(1'h1), .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .current_limit_lock_raw(lock_raw),
        .bus_voltage, .lock_retry_interval(16'h0004), .fault_indicator_n, .bridge_mode);
    motor_stage_model i_motor (.aclk, .lock_cmd, .volt_cmd, .bridge_mode, .lock_raw,
        .bus_voltage);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // each channel held until its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        rd_data = rdata;
        chk(32'(rresp), 32'(er));
    endtask : rd
    task automatic pins(input logic [2:0] e);
        chk(32'({fault_indicator_n, bridge_mode}), 32'(e));
    endtask : pins
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // a hung handshake ends the run
    initial begin
        repeat (8000) @(posedge aclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(SETTINGS_OFFSET, AXI_OKAY);
        chk(rd_data, SETTINGS_RESET);
        rd(8'h0C, AXI_SLVERR);
        chk(rd_data, 32'h0);
        wr(8'h0C, 32'hFFFF_FFFF, AXI_SLVERR);
        wr(STATUS_OFFSET, 32'hFFFF_FFFF, AXI_OKAY);
        // each response code with a limit of two retries
        for (int c = 0; c < 8; c++) begin
            wr(SETTINGS_OFFSET, (32'(c) << RESPONSE_LSB) | 32'h1, AXI_OKAY);
            lock_cmd <= 1'h1;
            repeat (80) @(posedge aclk);
            pins(exp_lock[c]);
            rd(STATUS_OFFSET, AXI_OKAY);
            chk(32'(rd_data[12:8]), (c inside {[3:5]}) ? 32'h2 : 32'h0);
            lock_cmd <= 1'h0;
            repeat (10) @(posedge aclk);
            wr(CONTROL_OFFSET, 32'h1, AXI_OKAY);
            rd(STATUS_OFFSET, AXI_OKAY);
            chk(32'(rd_data[12:8]), 32'h0);
            pins(3'h4);
        end
        // longest filter: short pulse ignored, held one latches
        wr(SETTINGS_OFFSET, 32'h0000_E000, AXI_OKAY);
        lock_cmd <= 1'h1;
        repeat (100) @(posedge aclk);
        lock_cmd <= 1'h0;
        repeat (50) @(posedge aclk);
        pins(3'h4);
        lock_cmd <= 1'h1;
        repeat (130) @(posedge aclk);
        pins(3'h4);
        repeat (20) @(posedge aclk);
        pins(3'h1);
        lock_cmd <= 1'h0;
        repeat (10) @(posedge aclk);
        wr(CONTROL_OFFSET, 32'h1, AXI_OKAY);
        // uv 6 V, ov 18 V, half-volt hysteresis, auto recovery
        wr(SETTINGS_OFFSET, 32'h0007_0198, AXI_OKAY);
        for (int i = 0; i < 7; i++) begin
            volt_cmd <= volt[i];
            repeat (4) @(posedge aclk);
            pins(exp_v[i]);
        end
        // latched undervoltage holds until cleared
        wr(SETTINGS_OFFSET, 32'h0007_0100, AXI_OKAY);
        volt_cmd <= 8'h0C;
        repeat (4) @(posedge aclk);
        volt_cmd <= 8'h18;
        repeat (4) @(posedge aclk);
        pins(3'h1);
        wr(CONTROL_OFFSET, 32'h1, AXI_OKAY);
        pins(3'h4);
        end_sim();
    end
endmodule : current_limit_lock_fault_policy_bench
`default_nettype wire
